// ==== hw/cap_sense_regs.sv ====
// Register bank of the two-channel capacitance front end with standby rates and interrupts.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each offset register holds a 6-bit code, one picofarad per step, up to 63.
// - Unused upper bits of offset, divider, subdivider and enable registers read zero.
// - Any reset clears both offset registers and the interrupt enable register.
// - Any reset loads the standby divider and channel 2 subdivider with one.
// - In standby channel 1 converts slower by the 5-bit shared divider.
// - In standby channel 2 divides by shared divider times its own subdivider.
// - Enable bit 0 lets a channel 1 ready flag raise the interrupt.
// - Enable bit 1 lets a channel 2 ready flag raise the interrupt.
// - Enable bit 2 lets a channel 1 wake-up event raise the interrupt.
// - Enable bit 3 lets a channel 2 wake-up event raise the interrupt.
// - A cleared enable bit keeps its source from causing any interrupt.
// - Standby wake-up compares results against enabled absolute or rate-of-change limits.
module cap_sense_regs
  import cap_sense_pkg::*;
(
  input  wire logic                              ref_clk,
  input  wire logic                              nrst,
  input  wire logic [cap_sense_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [cap_sense_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [cap_sense_pkg::DATA_W-1:0]   avs_readdata,
  output logic                                   avs_waitrequest,
  input  wire logic                              standby,
  input  wire logic                              conv_tick,
  input  wire logic [cap_sense_pkg::RESULT_W-1:0] ch1_result,
  input  wire logic                              ch1_result_valid,
  input  wire logic [cap_sense_pkg::RESULT_W-1:0] ch2_result,
  input  wire logic                              ch2_result_valid,
  input  wire logic [cap_sense_pkg::THR_W-1:0]    ch1_abs_thresh,
  input  wire logic [cap_sense_pkg::THR_W-1:0]    ch1_roc_thresh,
  input  wire logic [cap_sense_pkg::THR_W-1:0]    ch2_abs_thresh,
  input  wire logic [cap_sense_pkg::THR_W-1:0]    ch2_roc_thresh,
  output logic      [cap_sense_pkg::OFFSET_W-1:0] ch1_cap_offset_code,
  output logic      [cap_sense_pkg::OFFSET_W-1:0] ch2_cap_offset_code,
  output logic                                   ch1_conv_start,
  output logic                                   ch2_conv_start,
  output logic                                   irq
);

  import cap_sense_pkg::*;

  // ---------------------------------------------------------------------------
  // State of the bank
  // ---------------------------------------------------------------------------

  // All software-visible fields plus the bus answer state live in one record.
  typedef struct packed {
    logic [OFFSET_W-1:0] off1;
    logic [OFFSET_W-1:0] off2;
    logic [DIV_W-1:0]    div;
    logic [DIV_W-1:0]    sub;
    logic [EVT_W-1:0]    ien;
    logic [EVT_W-1:0]    stat;
    logic [EVT_W-1:0]    thr_en;
    logic                ack;
    logic [REG_W-1:0]    rdata;
    logic                irq;
  } regs_t;

  regs_t s_q;
  regs_t s_d;

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------

  // True when a byte address selects the register at the given index.
  function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    idx_hit = (addr[ADDR_W-1:IDX_LSB] == idx);
  endfunction

  // Read value of a register; every bit above a field reads as zero.
  function automatic logic [REG_W-1:0] read_value(input logic [ADDR_W-1:0] addr,
                                                  input regs_t r);
    read_value = '0;
    if (idx_hit(addr, IDX_CH1_OFFSET)) begin
      read_value = REG_W'(r.off1);
    end else if (idx_hit(addr, IDX_CH2_OFFSET)) begin
      read_value = REG_W'(r.off2);
    end else if (idx_hit(addr, IDX_STBY_DIV)) begin
      read_value = REG_W'(r.div);
    end else if (idx_hit(addr, IDX_CH2_SUBDIV)) begin
      read_value = REG_W'(r.sub);
    end else if (idx_hit(addr, IDX_IRQ_ENABLE)) begin
      read_value = REG_W'(r.ien);
    end else if (idx_hit(addr, IDX_EVT_STATUS)) begin
      read_value = REG_W'(r.stat);
    end else if (idx_hit(addr, IDX_THR_ENABLE)) begin
      read_value = REG_W'(r.thr_en);
    end
  endfunction

  // A zero divide field behaves as a ratio of one.
  function automatic logic [DIV_W-1:0] nonzero(input logic [DIV_W-1:0] v);
    nonzero = (v == '0) ? DIV_W'(1) : v;
  endfunction

  // ---------------------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------------------

  logic             ch1_wake;
  logic             ch2_wake;
  logic [EVT_W-1:0] evt;
  logic [PROD_W-1:0] ch2_ratio;

  // Channel 1 wake-up detector, fed with the channel 1 limits and enables.
  wake_detect ch1_wake_det (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .result       (ch1_result),
    .result_valid (ch1_result_valid),
    .standby      (standby),
    .abs_thresh   (ch1_abs_thresh),
    .roc_thresh   (ch1_roc_thresh),
    .abs_en       (s_q.thr_en[THR_CH1_ABS]),
    .roc_en       (s_q.thr_en[THR_CH1_ROC]),
    .wake         (ch1_wake)
  );

  // Channel 2 wake-up detector, fed with the channel 2 limits and enables.
  wake_detect ch2_wake_det (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .result       (ch2_result),
    .result_valid (ch2_result_valid),
    .standby      (standby),
    .abs_thresh   (ch2_abs_thresh),
    .roc_thresh   (ch2_roc_thresh),
    .abs_en       (s_q.thr_en[THR_CH2_ABS]),
    .roc_en       (s_q.thr_en[THR_CH2_ROC]),
    .wake         (ch2_wake)
  );

  // Ready flags follow each finished conversion; wake flags follow the detectors.
  always_comb begin
    evt = '0;
    evt[EVT_CH1_READY] = ch1_result_valid;
    evt[EVT_CH2_READY] = ch2_result_valid;
    evt[EVT_CH1_WAKE] = ch1_wake;
    evt[EVT_CH2_WAKE] = ch2_wake;
  end

  // ---------------------------------------------------------------------------
  // Standby conversion rates
  // ---------------------------------------------------------------------------

  // Channel 2 divides by the product of both fields.
  assign ch2_ratio = PROD_W'(nonzero(s_q.div)) * PROD_W'(nonzero(s_q.sub));

  // Channel 1 start pulses, thinned by the shared divider in standby.
  standby_rate_div #(
    .RATIO_W (PROD_W)
  ) ch1_rate (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick_in  (conv_tick),
    .divide   (standby),
    .ratio    (PROD_W'(s_q.div)),
    .tick_out (ch1_conv_start)
  );

  // Channel 2 start pulses, thinned by divider times subdivider in standby.
  standby_rate_div #(
    .RATIO_W (PROD_W)
  ) ch2_rate (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick_in  (conv_tick),
    .divide   (standby),
    .ratio    (ch2_ratio),
    .tick_out (ch2_conv_start)
  );

  // ---------------------------------------------------------------------------
  // Bus slave and register update
  // ---------------------------------------------------------------------------

  logic             req;
  logic             wr_done;
  logic             rd_done;
  logic [EVT_W-1:0] stat_clr;

  // A request is answered on the second edge; writes land on that same edge.
  assign req = avs_read || avs_write;
  assign wr_done = s_q.ack && avs_write && avs_byteenable[0];
  assign rd_done = s_q.ack && avs_read;

  // Status read clears only the bits it returned, so a later event survives.
  assign stat_clr = (rd_done && idx_hit(avs_address, IDX_EVT_STATUS)) ?
                    s_q.rdata[EVT_W-1:0] : '0;

  // Next state of every register and of the bus answer.
  always_comb begin
    s_d = s_q;
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack) begin
      s_d.rdata = read_value(avs_address, s_q);
    end
    if (wr_done && idx_hit(avs_address, IDX_CH1_OFFSET)) begin
      s_d.off1 = avs_writedata[OFFSET_W-1:0];
    end
    if (wr_done && idx_hit(avs_address, IDX_CH2_OFFSET)) begin
      s_d.off2 = avs_writedata[OFFSET_W-1:0];
    end
    if (wr_done && idx_hit(avs_address, IDX_STBY_DIV)) begin
      s_d.div = avs_writedata[DIV_W-1:0];
    end
    if (wr_done && idx_hit(avs_address, IDX_CH2_SUBDIV)) begin
      s_d.sub = avs_writedata[DIV_W-1:0];
    end
    if (wr_done && idx_hit(avs_address, IDX_IRQ_ENABLE)) begin
      s_d.ien = avs_writedata[EVT_W-1:0];
    end
    if (wr_done && idx_hit(avs_address, IDX_THR_ENABLE)) begin
      s_d.thr_en = avs_writedata[EVT_W-1:0];
    end
    s_d.stat = (s_q.stat & ~stat_clr) | evt;
    s_d.irq = |(s_d.stat & s_d.ien);
  end

  // State register with the documented reset values.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.off1 <= OFFSET_RST;
      s_q.off2 <= OFFSET_RST;
      s_q.ien <= IEN_RST;
      s_q.div <= DIV_RST;
      s_q.sub <= SUBDIV_RST;
      s_q.stat <= STAT_RST;
      s_q.thr_en <= THR_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  // Offset codes go straight to the analog front end.
  assign ch1_cap_offset_code = s_q.off1;
  assign ch2_cap_offset_code = s_q.off2;
  assign avs_readdata = DATA_W'(s_q.rdata);
  assign avs_waitrequest = req && !s_q.ack;
  assign irq = s_q.irq;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic ien_wr;
  assign ien_wr = wr_done && idx_hit(avs_address, IDX_IRQ_ENABLE);

  // Bus steps: a fresh request, then its answer one edge later.
  sequence s_bus_req;
    req && !s_q.ack;
  endsequence

  sequence s_bus_done;
    req && !avs_waitrequest;
  endsequence

  a_bus_answer : assert property (s_bus_req |=> s_bus_done)
    else $error("Bus request not answered on the following edge.");

  a_offset_write : assert property (
    (s_bus_done and (avs_write && avs_byteenable[0] && idx_hit(avs_address, IDX_CH1_OFFSET)))
    |=> (ch1_cap_offset_code == $past(avs_writedata[OFFSET_W-1:0])))
    else $error("Channel 1 offset code did not take the written value.");

  a_reserved_zero : assert property (
    (s_bus_done and avs_read) |->
      ((avs_readdata[DATA_W-1:8] == '0) &&
       (!(idx_hit(avs_address, IDX_CH1_OFFSET) || idx_hit(avs_address, IDX_CH2_OFFSET))
        || (avs_readdata[7:6] == 2'h0)) &&
       (!(idx_hit(avs_address, IDX_STBY_DIV) || idx_hit(avs_address, IDX_CH2_SUBDIV))
        || (avs_readdata[7:5] == 3'h0)) &&
       (!idx_hit(avs_address, IDX_IRQ_ENABLE) || (avs_readdata[7:4] == 4'h0))))
    else $error("Reserved register bits did not read as zero.");

  a_reset_clear : assert property ($rose(nrst) |->
    ((ch1_cap_offset_code == OFFSET_RST) && (ch2_cap_offset_code == OFFSET_RST) &&
     (s_q.ien == IEN_RST)))
    else $error("Offset or enable register not cleared by reset.");

  a_reset_one : assert property ($rose(nrst) |->
    ((s_q.div == DIV_RST) && (s_q.sub == SUBDIV_RST)))
    else $error("Divider or subdivider not loaded with one by reset.");

  a_active_rate : assert property ((!standby && conv_tick) |=>
    (ch1_conv_start && ch2_conv_start))
    else $error("Outside standby a base tick did not start both channels.");

  a_ready1_irq : assert property ((ch1_result_valid && s_q.ien[EVT_CH1_READY] && !ien_wr) |=>
    irq)
    else $error("Enabled channel 1 ready flag did not raise the interrupt.");

  a_ready2_irq : assert property ((ch2_result_valid && s_q.ien[EVT_CH2_READY] && !ien_wr) |=>
    irq)
    else $error("Enabled channel 2 ready flag did not raise the interrupt.");

  a_wake1_irq : assert property ((ch1_wake && s_q.ien[EVT_CH1_WAKE] && !ien_wr) |=> irq)
    else $error("Enabled channel 1 wake event did not raise the interrupt.");

  a_wake2_irq : assert property ((ch2_wake && s_q.ien[EVT_CH2_WAKE] && !ien_wr) |=> irq)
    else $error("Enabled channel 2 wake event did not raise the interrupt.");

  a_masked_quiet : assert property (((s_q.ien == '0) && !ien_wr) |=> !irq)
    else $error("Interrupt raised while every source was disabled.");

  a_irq_or : assert property (irq == |(s_q.stat & s_q.ien))
    else $error("Interrupt output differs from the enabled status bits.");

  a_event_sticky : assert property ((evt != '0) |=>
    ((s_q.stat & $past(evt)) == $past(evt)))
    else $error("An event did not leave its status bit set.");

  a_status_clear : assert property (
    (rd_done && idx_hit(avs_address, IDX_EVT_STATUS)) |=>
    ((s_q.stat & $past(s_q.rdata[EVT_W-1:0]) & ~$past(evt)) == '0))
    else $error("Status bits returned by a read were not cleared.");

  a_offset2_write : assert property (
    (s_bus_done and (avs_write && avs_byteenable[0] && idx_hit(avs_address, IDX_CH2_OFFSET)))
    |=> (ch2_cap_offset_code == $past(avs_writedata[OFFSET_W-1:0])))
    else $error("Channel 2 offset code did not take the written value.");

endmodule

`default_nettype wire

// ==== hw/cap_sense_pkg.sv ====
// Package holding the register map, field layout and reset values of the sense front-end registers.
package cap_sense_pkg;

  // ---------------------------------------------------------------------------
  // Bus and data widths
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned IDX_W    = 6;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned OFFSET_W = 6;
  localparam int unsigned DIV_W    = 5;
  localparam int unsigned PROD_W   = 10;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned THR_W    = 8;
  localparam int unsigned THR_LSB  = 4;
  localparam int unsigned EVT_W    = 4;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address of a register is four times its index
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CH1_OFFSET = 6'h10;
  localparam logic [IDX_W-1:0] IDX_CH2_OFFSET = 6'h11;
  localparam logic [IDX_W-1:0] IDX_STBY_DIV   = 6'h12;
  localparam logic [IDX_W-1:0] IDX_CH2_SUBDIV = 6'h13;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h14;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 6'h15;
  localparam logic [IDX_W-1:0] IDX_THR_ENABLE = 6'h16;

  // ---------------------------------------------------------------------------
  // Field positions of the event, enable and threshold-enable registers
  // ---------------------------------------------------------------------------
  localparam int unsigned EVT_CH1_READY = 0;
  localparam int unsigned EVT_CH2_READY = 1;
  localparam int unsigned EVT_CH1_WAKE  = 2;
  localparam int unsigned EVT_CH2_WAKE  = 3;
  localparam int unsigned THR_CH1_ABS   = 0;
  localparam int unsigned THR_CH1_ROC   = 1;
  localparam int unsigned THR_CH2_ABS   = 2;
  localparam int unsigned THR_CH2_ROC   = 3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 6'h00;
  localparam logic [DIV_W-1:0]    DIV_RST    = 5'h01;
  localparam logic [DIV_W-1:0]    SUBDIV_RST = 5'h01;
  localparam logic [EVT_W-1:0]    IEN_RST    = 4'h0;
  localparam logic [EVT_W-1:0]    STAT_RST   = 4'h0;
  localparam logic [EVT_W-1:0]    THR_EN_RST = 4'h0;

endpackage

// ==== hw/standby_rate_div.sv ====
// Conversion tick divider that thins the base tick by a ratio while standby is in force.
`timescale 1ns/1ps
`default_nettype none

module standby_rate_div #(
  parameter int unsigned RATIO_W = 10
) (
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic               tick_in,
  input  wire logic               divide,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    tick_out
);

  typedef struct packed {
    logic [RATIO_W-1:0] cnt;
    logic               pulse;
  } div_state_t;

  div_state_t         s_q;
  div_state_t         s_d;
  logic [RATIO_W-1:0] ratio_eff;

  // A zero ratio behaves as one; the counter wraps after ratio ticks in standby.
  always_comb begin
    ratio_eff = (ratio == '0) ? RATIO_W'(1) : ratio;
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (tick_in) begin
      if (!divide || (s_q.cnt >= ratio_eff - RATIO_W'(1))) begin
        s_d.cnt = '0;
        s_d.pulse = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + RATIO_W'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.pulse;

  // Helper: ticks seen since the last output pulse, and whether the ratio held still.
  logic [RATIO_W:0]   seen_q;
  logic               steady_q;
  logic [RATIO_W-1:0] ratio_prev_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seen_q <= '0;
      steady_q <= 1'b0;
      ratio_prev_q <= '0;
    end else begin
      seen_q <= (s_q.pulse ? '0 : seen_q) + (RATIO_W+1)'(tick_in);
      steady_q <= s_q.pulse ? 1'b1 : (steady_q && divide && (ratio == ratio_prev_q));
      ratio_prev_q <= ratio;
    end
  end

  a_tick_spacing : assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_q.pulse && divide && steady_q && $stable(ratio)) |-> (seen_q == (RATIO_W+1)'(ratio_eff)))
    else $error("Standby pulse spacing differs from the divide ratio.");

endmodule

`default_nettype wire

// ==== hw/wake_detect.sv ====
// Standby wake-up detector comparing each conversion against absolute and rate-of-change limits.
`timescale 1ns/1ps
`default_nettype none

module wake_detect
  import cap_sense_pkg::*;
(
  input  wire logic                              ref_clk,
  input  wire logic                              nrst,
  input  wire logic [cap_sense_pkg::RESULT_W-1:0] result,
  input  wire logic                              result_valid,
  input  wire logic                              standby,
  input  wire logic [cap_sense_pkg::THR_W-1:0]    abs_thresh,
  input  wire logic [cap_sense_pkg::THR_W-1:0]    roc_thresh,
  input  wire logic                              abs_en,
  input  wire logic                              roc_en,
  output logic                                    wake
);

  import cap_sense_pkg::*;

  typedef struct packed {
    logic [RESULT_W-1:0] prev;
    logic                primed;
    logic                wake;
  } wake_state_t;

  wake_state_t         s_q;
  wake_state_t         s_d;
  logic [RESULT_W-1:0] delta;
  logic                abs_hit;
  logic                roc_hit;

  // Only enabled limits count; the rate limit needs one earlier result to compare with.
  always_comb begin
    delta = (result >= s_q.prev) ? (result - s_q.prev) : (s_q.prev - result);
    abs_hit = abs_en && (result[RESULT_W-1:THR_LSB] > abs_thresh);
    roc_hit = roc_en && s_q.primed && (delta[RESULT_W-1:THR_LSB] > roc_thresh);
    s_d = s_q;
    s_d.wake = 1'b0;
    if (result_valid) begin
      s_d.prev = result;
      s_d.primed = 1'b1;
      s_d.wake = standby && (abs_hit || roc_hit);
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wake = s_q.wake;

  a_wake_cause : assert property (@(posedge ref_clk) disable iff (!nrst)
    wake |-> $past(result_valid && standby))
    else $error("Wake event without a standby conversion.");

  a_abs_wake : assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_valid && standby && abs_en && (result[RESULT_W-1:THR_LSB] > abs_thresh)) |=> wake)
    else $error("Absolute limit crossed in standby without a wake event.");

endmodule

`default_nettype wire

// ==== bench/cap_sense_regs_tb.sv ====
// Self-checking testbench for the sense front-end register bank.
`timescale 1ns/1ps
`default_nettype none

module cap_sense_regs_tb;
  import cap_sense_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus and observation signals
  // ---------------------------------------------------------------------------
  logic        ref_clk, nrst, avs_read, avs_write, standby, conv_tick;
  logic        ch1_result_valid, ch2_result_valid, avs_waitrequest;
  logic        ch1_conv_start, ch2_conv_start, irq;
  logic [7:0]  avs_address, ch1_abs_thresh, ch1_roc_thresh, ch2_abs_thresh, ch2_roc_thresh;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [11:0] ch1_result, ch2_result;
  logic [5:0]  ch1_cap_offset_code, ch2_cap_offset_code;
  int          error_cnt, total_checks, c1, c2;

  cap_sense_regs uut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .standby(standby), .conv_tick(conv_tick),
    .ch1_result(ch1_result), .ch1_result_valid(ch1_result_valid), .ch2_result(ch2_result),
    .ch2_result_valid(ch2_result_valid), .ch1_abs_thresh(ch1_abs_thresh),
    .ch1_roc_thresh(ch1_roc_thresh), .ch2_abs_thresh(ch2_abs_thresh),
    .ch2_roc_thresh(ch2_roc_thresh), .ch1_cap_offset_code(ch1_cap_offset_code),
    .ch2_cap_offset_code(ch2_cap_offset_code), .ch1_conv_start(ch1_conv_start),
    .ch2_conv_start(ch2_conv_start), .irq(irq));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Conversion start pulses are counted as they appear.
  always @(posedge ref_clk) begin
    if (ch1_conv_start === 1'b1) c1 <= c1 + 1;
    if (ch2_conv_start === 1'b1) c2 <= c2 + 1;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One bus cycle, held until waitrequest is sampled low.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) chk("bus_answer", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    chk(nm, x, {24'h0, e});
  endtask

  task automatic pulse(input logic p1, input logic p2);
    @(posedge ref_clk);
    ch1_result_valid <= p1;
    ch2_result_valid <= p2;
    @(posedge ref_clk);
    ch1_result_valid <= 1'b0;
    ch2_result_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      conv_tick <= 1'b1;
      @(posedge ref_clk);
      conv_tick <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (3) @(posedge ref_clk);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset();
    rd_chk(8'h40, 8'h00, "ch1_offset_rst");
    rd_chk(8'h44, 8'h00, "ch2_offset_rst");
    rd_chk(8'h48, 8'h01, "stby_div_rst");
    rd_chk(8'h4c, 8'h01, "ch2_subdiv_rst");
    rd_chk(8'h50, 8'h00, "irq_enable_rst");
    rd_chk(8'h7c, 8'h00, "unmapped_read");
  endtask

  // All-ones writes must read back with the unused upper bits clear.
  task automatic test_fields();
    logic [7:0] m [5] = '{8'h3f, 8'h3f, 8'h1f, 8'h1f, 8'h0f};
    for (int i = 0; i < 5; i++) begin
      wr(8'h40 + 8'(4 * i), 32'hffffffff);
      rd_chk(8'h40 + 8'(4 * i), m[i], "field_mask");
    end
    chk("ch1_code", 32'(ch1_cap_offset_code), 32'h3f);
    chk("ch2_code", 32'(ch2_cap_offset_code), 32'h3f);
    avs_byteenable <= 4'he;
    wr(8'h40, 32'h15);
    avs_byteenable <= 4'hf;
    wr(8'h44, 32'hea);
    @(posedge ref_clk);
    chk("ch1_code_kept", 32'(ch1_cap_offset_code), 32'h3f);
    chk("ch2_code_mid", 32'(ch2_cap_offset_code), 32'h2a);
  endtask

  // Ready events: the masked channel stays silent, the enabled one interrupts.
  task automatic test_irq();
    for (int i = 0; i < 2; i++) begin
      wr(8'h50, 32'(1 << i));
      pulse(i == 1, i == 0);
      chk("irq_masked", 32'(irq), 32'h0);
      rd_chk(8'h54, 8'(1 << (1 - i)), "status_masked");
      pulse(i == 0, i == 1);
      chk("irq_ready", 32'(irq), 32'h1);
      rd_chk(8'h54, 8'(1 << i), "status_ready");
      @(posedge ref_clk);
      chk("irq_cleared", 32'(irq), 32'h0);
    end
  endtask

  // Standby wake-up on both channels above and at or below the limit.
  task automatic test_wake();
    standby <= 1'b1;
    wr(8'h58, 32'h5);
    wr(8'h50, 32'hc);
    pulse(1'b1, 1'b1);
    chk("irq_wake", 32'(irq), 32'h1);
    rd_chk(8'h54, 8'h0f, "status_wake");
    ch1_result <= 12'h0f0;
    ch2_result <= 12'h100;
    pulse(1'b1, 1'b1);
    chk("irq_no_wake", 32'(irq), 32'h0);
    rd_chk(8'h54, 8'h03, "status_no_wake");
  endtask

  // Standby rate division, then full rate once standby ends.
  task automatic test_rate();
    int b1, b2;
    wr(8'h48, 32'h2);
    wr(8'h4c, 32'h3);
    b1 = c1;
    b2 = c2;
    ticks(12);
    chk("ch1_stby_starts", 32'(c1 - b1), 32'd6);
    chk("ch2_stby_starts", 32'(c2 - b2), 32'd2);
    standby <= 1'b0;
    b1 = c1;
    b2 = c2;
    ticks(3);
    chk("ch1_starts", 32'(c1 - b1), 32'd3);
    chk("ch2_starts", 32'(c2 - b2), 32'd3);
  endtask

  // Watchdog cuts a hang short well beyond the expected run time.
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  // Main sequence: reset, then every scenario in turn.
  initial begin
    {nrst, avs_read, avs_write, standby, conv_tick, ch1_result_valid} = '0;
    {ch2_result_valid, avs_address, avs_writedata, ch1_roc_thresh, ch2_roc_thresh} = '0;
    {error_cnt, total_checks, c1, c2} = '0;
    avs_byteenable = 4'hf;
    ch1_abs_thresh = 8'h10;
    ch2_abs_thresh = 8'h10;
    ch1_result = 12'h200;
    ch2_result = 12'h200;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    test_reset();
    test_fields();
    test_irq();
    test_wake();
    test_rate();
    give_verdict();
  end
endmodule

`default_nettype wire
